// >>> src/uhmr_pkg.sv
// Purpose: shared constants and types for the host controller misc register group
// Assumes: 16-bit command-coded register port, one clock
// Notes: command codes are the read and write codes of each register
package uhmr_pkg;
  localparam logic [7:0] UHMR_RD_ENABLE = 8'h25;
  localparam logic [7:0] UHMR_WR_ENABLE = 8'hA5;
  localparam logic [7:0] UHMR_RD_IDENT = 8'h27;
  localparam logic [7:0] UHMR_RD_SCRATCH = 8'h28;
  localparam logic [7:0] UHMR_WR_SCRATCH = 8'hA8;
  localparam logic [7:0] UHMR_WR_SOFTRST = 8'hA9;
  localparam logic [15:0] UHMR_SOFTRST_KEY = 16'h00F6;
  localparam logic [15:0] UHMR_SCRATCH_RST = 16'h0000;
  localparam logic [15:0] UHMR_ENABLE_RST = 16'h0000;
  // writable enable bits: 6,5,4,2,1,0
  localparam logic [15:0] UHMR_ENABLE_MASK = 16'h0077;
  localparam int UHMR_BIT_SOF = 0;
  localparam int UHMR_BIT_ASYNC = 1;
  localparam int UHMR_BIT_XEND = 2;
  localparam int UHMR_BIT_OPREG = 4;
  localparam int UHMR_BIT_SUSP = 5;
  localparam int UHMR_BIT_CLKRDY = 6;
  localparam logic [15:0] UHMR_RDATA_RST = 16'h0000;

  // one register access from the processor port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] code;
    logic [15:0] wdata;
  } uhmr_cmd_t;

  // read answer
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } uhmr_resp_t;
endpackage

// >>> src/uhmr_misc_regs.sv
// Purpose: misc register group: interrupt enable mask, identification, scratch, soft reset
// Assumes: one clk at 25 MHz, async active-low nrst, one command per cycle at most
// Notes: read data answers one cycle after the command; soft reset spares buffer memory
//
// Behaviour
// - enable bit 6 lets the clock-ready event raise the interrupt.
// - enable bit 5 lets the controller-suspended event raise the interrupt.
// - enable bit 4 lets the operational-register update event interrupt.
// - enable bit 2 lets the end-of-transfer event interrupt.
// - enable bit 1 lets the async transfer list event interrupt.
// - enable bit 0 lets the SOF-driven iso event interrupt.
// - identification register is read-only on code 27, no write code.
// - identification upper byte is product, lower byte is revision.
// - scratch is 16-bit read/write, codes 28/A8, resets to zero.
// - reset value returns all registers to reset, buffer memory untouched.
// - after power-on all enable bits are zero, so no interrupt.
// - interrupt needs status bit, its enable, and global enable set.
`timescale 1ns/1ps
`default_nettype none
module uhmr_misc_regs #(
  parameter logic [7:0] PRODUCT_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h01 // arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire uhmr_pkg::uhmr_cmd_t cmd,
  input wire logic [15:0] irq_status,
  input wire logic global_irq_en,
  output uhmr_pkg::uhmr_resp_t resp,
  output logic irq,
  output logic soft_reset_pulse,
  output logic [15:0] irq_enable
);
  import uhmr_pkg::*;

  logic [15:0] enable_reg;
  logic [15:0] scratch_reg;
  logic swrst_reg;
  logic irq_reg;
  uhmr_resp_t resp_reg;
  logic swrst_hit;

  function automatic logic [15:0] uhmr_masked(input logic [15:0] v);
    uhmr_masked = v & UHMR_ENABLE_MASK;
  endfunction

  // soft reset fires only on the exact key; any other value is dropped
  assign swrst_hit = cmd.wr && (cmd.code == UHMR_WR_SOFTRST)
    && (cmd.wdata == UHMR_SOFTRST_KEY);

  // one-cycle soft reset strobe, also offered to the rest of the controller
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      swrst_reg <= 1'b0;
    else
      swrst_reg <= swrst_hit;
  end

  // interrupt enable mask; reserved bits can never be written
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      enable_reg <= UHMR_ENABLE_RST;
    else if (swrst_hit)
      enable_reg <= UHMR_ENABLE_RST;
    else if (cmd.wr && cmd.code == UHMR_WR_ENABLE)
      enable_reg <= uhmr_masked(cmd.wdata);
  end

  // scratch store, no side effects
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      scratch_reg <= UHMR_SCRATCH_RST;
    else if (swrst_hit)
      scratch_reg <= UHMR_SCRATCH_RST;
    else if (cmd.wr && cmd.code == UHMR_WR_SCRATCH)
      scratch_reg <= cmd.wdata;
  end

  // read port; the identification code has no write code, writes ignore it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      resp_reg <= '{valid: 1'b0, data: UHMR_RDATA_RST};
    else
    begin
      resp_reg.valid <= cmd.rd;
      if (!cmd.rd)
        resp_reg.data <= UHMR_RDATA_RST;
      else if (cmd.code == UHMR_RD_ENABLE)
        resp_reg.data <= uhmr_masked(enable_reg);
      else if (cmd.code == UHMR_RD_IDENT)
        resp_reg.data <= {PRODUCT_ID, REVISION_ID};
      else if (cmd.code == UHMR_RD_SCRATCH)
        resp_reg.data <= scratch_reg;
      else
        resp_reg.data <= UHMR_RDATA_RST; // unmapped reads give zero
    end
  end

  // interrupt: any enabled source, gated by the global enable; reserved bits inert
  // registered so the pin is glitch-free, at the cost of one cycle latency
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq_reg <= 1'b0;
    else
      irq_reg <= global_irq_en && !swrst_hit
        && |(irq_status & uhmr_masked(enable_reg));
  end

  // suspend is driven by the main control register elsewhere the enable only masks it
  assign resp = resp_reg;
  assign irq = irq_reg;
  assign soft_reset_pulse = swrst_reg;
  assign irq_enable = enable_reg;

  // soft reset clears the whole register set in one edge
  a_enable_reset: assert property (@(posedge clk) disable iff (!nrst)
    swrst_hit |=> (enable_reg == 16'h0000 && scratch_reg == 16'h0000))
    else $error("soft reset did not clear registers");

  // a near miss on the key must not fire the strobe
  a_bad_key_inert: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.wr && cmd.code == UHMR_WR_SOFTRST && cmd.wdata != 16'h00F6) |=> !swrst_reg)
    else $error("soft reset fired on wrong value");

  // reserved bits never hold a one
  a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
    (enable_reg & 16'hFF88) == 16'h0000)
    else $error("reserved enable bit set");

  // no interrupt without an enabled cause and the global enable
  a_irq_gated: assert property (@(posedge clk) disable iff (!nrst)
    irq |-> $past(global_irq_en) && ($past(irq_status) & $past(enable_reg)) != 16'h0000)
    else $error("interrupt without enabled cause");

  // clock-ready source raises the pin when enabled
  a_irq_raise: assert property (@(posedge clk) disable iff (!nrst)
    (global_irq_en && !swrst_hit && irq_status[6] && enable_reg[6]) |=> irq)
    else $error("clock ready interrupt missing");

  // clock-ready source stays quiet when masked
  a_clkrdy_mask: assert property (@(posedge clk) disable iff (!nrst)
    (irq_status == 16'h0040 && !enable_reg[6]) |=> !irq)
    else $error("masked clock ready interrupt seen");

  // suspend source raises the pin when enabled
  a_susp_raise: assert property (@(posedge clk) disable iff (!nrst)
    (global_irq_en && !swrst_hit && irq_status[5] && enable_reg[5]) |=> irq)
    else $error("suspend interrupt missing");

  // suspend source stays quiet when masked
  a_susp_mask: assert property (@(posedge clk) disable iff (!nrst)
    (irq_status == 16'h0020 && !enable_reg[5]) |=> !irq)
    else $error("masked suspend interrupt seen");

  // operational-register source raises the pin when enabled
  a_opreg_raise: assert property (@(posedge clk) disable iff (!nrst)
    (global_irq_en && !swrst_hit && irq_status[4] && enable_reg[4]) |=> irq)
    else $error("opreg interrupt missing");

  // operational-register source stays quiet when masked
  a_opreg_mask: assert property (@(posedge clk) disable iff (!nrst)
    (irq_status == 16'h0010 && !enable_reg[4]) |=> !irq)
    else $error("masked opreg interrupt seen");

  // end-of-transfer source raises the pin when enabled
  a_xend_raise: assert property (@(posedge clk) disable iff (!nrst)
    (global_irq_en && !swrst_hit && irq_status[2] && enable_reg[2]) |=> irq)
    else $error("transfer end interrupt missing");

  // end-of-transfer source stays quiet when masked
  a_xend_mask: assert property (@(posedge clk) disable iff (!nrst)
    (irq_status == 16'h0004 && !enable_reg[2]) |=> !irq)
    else $error("masked transfer end interrupt seen");

  // async list source raises the pin when enabled
  a_async_raise: assert property (@(posedge clk) disable iff (!nrst)
    (global_irq_en && !swrst_hit && irq_status[1] && enable_reg[1]) |=> irq)
    else $error("async list interrupt missing");

  // async list source stays quiet when masked
  a_async_mask: assert property (@(posedge clk) disable iff (!nrst)
    (irq_status == 16'h0002 && !enable_reg[1]) |=> !irq)
    else $error("masked async list interrupt seen");

  // frame-start iso source raises the pin when enabled
  a_sof_raise: assert property (@(posedge clk) disable iff (!nrst)
    (global_irq_en && !swrst_hit && irq_status[0] && enable_reg[0]) |=> irq)
    else $error("frame start interrupt missing");

  // frame-start iso source stays quiet when masked
  a_sof_mask: assert property (@(posedge clk) disable iff (!nrst)
    (irq_status == 16'h0001 && !enable_reg[0]) |=> !irq)
    else $error("masked frame start interrupt seen");

  // identification read returns the fixed code
  a_ident_read: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.rd && cmd.code == 8'h27) |=> resp.valid && resp.data == {PRODUCT_ID, REVISION_ID})
    else $error("identification read wrong");

  // a write aimed at the identification code changes nothing
  a_ident_nowrite: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.wr && cmd.code == UHMR_RD_IDENT) |=> $stable(enable_reg) && $stable(scratch_reg))
    else $error("identification write had an effect");

  // product byte sits in the upper half
  a_ident_upper: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.rd && cmd.code == UHMR_RD_IDENT) |=> resp.data[15:8] == PRODUCT_ID)
    else $error("identification product byte wrong");

  // revision byte sits in the lower half
  a_ident_lower: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.rd && cmd.code == UHMR_RD_IDENT) |=> resp.data[7:0] == REVISION_ID)
    else $error("identification revision byte wrong");

  // back-to-back write then read of scratch
  a_scratch_rw: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.wr && cmd.code == 8'hA8) ##1 (cmd.rd && cmd.code == 8'h28 && !cmd.wr)
      |=> resp.data == $past(cmd.wdata, 2))
    else $error("scratch readback wrong");

  // write then read of scratch with one idle cycle between
  a_scratch_gap: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.wr && cmd.code == 8'hA8) ##1 !cmd.wr ##1 (cmd.rd && cmd.code == 8'h28 && !cmd.wr)
      |=> resp.data == $past(cmd.wdata, 3))
    else $error("scratch readback after gap wrong");

  // scratch write lands whole on the next edge
  a_scratch_land: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.wr && cmd.code == UHMR_WR_SCRATCH) |=> scratch_reg == $past(cmd.wdata))
    else $error("scratch write lost");

  // scratch keeps its value when not written, no side effects
  a_scratch_hold: assert property (@(posedge clk) disable iff (!nrst)
    (!(cmd.wr && cmd.code == UHMR_WR_SCRATCH) && !swrst_hit) |=> $stable(scratch_reg))
    else $error("scratch changed without a write");

  // the key produces the strobe on the next edge
  a_key_pulse: assert property (@(posedge clk) disable iff (!nrst)
    swrst_hit |=> soft_reset_pulse)
    else $error("soft reset strobe missing");

  // the strobe only ever follows a key write
  a_pulse_cause: assert property (@(posedge clk) disable iff (!nrst)
    soft_reset_pulse |-> $past(swrst_hit))
    else $error("soft reset strobe without key");

  // soft reset also drops the interrupt pin
  a_reset_irq_low: assert property (@(posedge clk) disable iff (!nrst)
    swrst_hit |=> !irq)
    else $error("interrupt survived soft reset");

  // enable mask keeps its value when not written
  a_enable_hold: assert property (@(posedge clk) disable iff (!nrst)
    (!(cmd.wr && cmd.code == UHMR_WR_ENABLE) && !swrst_hit) |=> $stable(enable_reg))
    else $error("enable mask changed without a write");

  // with every enable clear the pin stays low
  a_masked_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (enable_reg == 16'h0000) |=> !irq)
    else $error("interrupt with all enables clear");

  // global enable off keeps the pin low
  a_global_off: assert property (@(posedge clk) disable iff (!nrst)
    !global_irq_en |=> !irq)
    else $error("interrupt with global enable off");

  // no status, no interrupt
  a_no_status: assert property (@(posedge clk) disable iff (!nrst)
    (irq_status == 16'h0000) |=> !irq)
    else $error("interrupt without status");

  // wrong key leaves the scratch store alone
  a_bad_key_keep: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.wr && cmd.code == UHMR_WR_SOFTRST && cmd.wdata != UHMR_SOFTRST_KEY)
      |=> $stable(scratch_reg))
    else $error("wrong key cleared scratch");

  // reserved enable bits read back as zero
  a_reserved_read: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.rd && cmd.code == UHMR_RD_ENABLE) |=> (resp.data & 16'hFF88) == 16'h0000)
    else $error("reserved enable bit read as one");

  // unmapped read codes answer zero
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.rd && cmd.code != UHMR_RD_ENABLE && cmd.code != UHMR_RD_IDENT
      && cmd.code != UHMR_RD_SCRATCH) |=> resp.data == 16'h0000)
    else $error("unmapped read not zero");

  // status on reserved positions alone never interrupts
  a_reserved_inert: assert property (@(posedge clk) disable iff (!nrst)
    ((irq_status & 16'h0077) == 16'h0000) |=> !irq)
    else $error("reserved status bit raised interrupt");

  // every enable write is masked and lands on the next edge
  a_enable_write: assert property (@(posedge clk) disable iff (!nrst)
    (cmd.wr && cmd.code == 8'hA5) |=> enable_reg == ($past(cmd.wdata) & 16'h0077))
    else $error("enable write lost");

  // the read answer stands exactly one cycle after the strobe
  a_resp_valid: assert property (@(posedge clk) disable iff (!nrst)
    cmd.rd |=> resp.valid)
    else $error("read answer missing");

  // no answer and zero data without a read strobe
  a_resp_idle: assert property (@(posedge clk) disable iff (!nrst)
    !cmd.rd |=> !resp.valid && resp.data == 16'h0000)
    else $error("read answer without strobe");

  // main scenarios reached
  c_soft_reset: cover property (@(posedge clk) disable iff (!nrst) swrst_reg);
  c_irq_seen: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));
  c_scratch_rd: cover property (@(posedge clk) disable iff (!nrst)
    cmd.rd && cmd.code == 8'h28);
  c_ident_rd: cover property (@(posedge clk) disable iff (!nrst)
    cmd.rd && cmd.code == UHMR_RD_IDENT);
  c_bad_key: cover property (@(posedge clk) disable iff (!nrst)
    cmd.wr && cmd.code == UHMR_WR_SOFTRST && cmd.wdata != UHMR_SOFTRST_KEY);
endmodule // uhmr_misc_regs
`default_nettype wire

// >>> verif/uhmr_host_model.sv
// Purpose: host processor model issuing command-coded accesses
// Assumes: one strobe cycle per access
// Notes: released code and data lines show inverted values, never the last ones; strobes drop to zero
`timescale 1ns/1ps
`default_nettype none
module uhmr_host_model (
  input wire logic clk,
  output var uhmr_pkg::uhmr_cmd_t cmd
);
  import uhmr_pkg::*;
  initial cmd = '0;
  // strobe for a single edge, then release
  task automatic access(input logic rd, input logic wr, input logic [7:0] code,
    input logic [15:0] wdata);
  begin
    @(posedge clk);
    #1 cmd = '{rd: rd, wr: wr, code: code, wdata: wdata};
    @(posedge clk);
    #1 cmd = '{rd: 1'b0, wr: 1'b0, code: ~code, wdata: ~wdata};
  end
  endtask
endmodule // uhmr_host_model
`default_nettype wire

// >>> verif/usb_host_misc_regs_tb.sv
// Purpose: self-checking bench for the misc register group
// Assumes: default identity parameters
// Notes: reads are matched in order against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module usb_host_misc_regs_tb;
  import uhmr_pkg::*;
  logic clk;
  logic nrst;
  logic [15:0] irq_status;
  logic global_irq_en;
  uhmr_cmd_t cmd;
  uhmr_resp_t resp;
  logic irq;
  logic soft_reset_pulse;
  logic [15:0] irq_enable;
  logic [15:0] exp_q[$];
  logic [15:0] sdata;
  int bits[6] = '{0, 1, 2, 4, 5, 6};
  int n_fail = 0;
  int n_checks = 0;
  int pulses = 0;
  uhmr_host_model host_u (.clk(clk), .cmd(cmd));
  uhmr_misc_regs dut_u (.clk(clk), .nrst(nrst), .cmd(cmd), .irq_status(irq_status),
    .global_irq_en(global_irq_en), .resp(resp), .irq(irq),
    .soft_reset_pulse(soft_reset_pulse), .irq_enable(irq_enable));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
  begin
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task automatic close_out;
  begin
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
  begin
    exp_q.push_back(exp);
    host_u.access(1'b1, 1'b0, code, 16'h0000);
  end
  endtask
  // irq follows its cause one cycle late, so give it two edges
  task automatic irq_chk(input logic e);
  begin
    repeat (2) @(posedge clk);
    #1 check("irq", {15'h0000, irq}, {15'h0000, e});
  end
  endtask
  // an answer with no note pending compares against unknown and fails
  always @(negedge clk)
  begin
    if (resp.valid === 1'b1)
      check("read data", resp.data, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
    if (soft_reset_pulse === 1'b1)
      pulses++;
  end
  initial
  begin
    #100000;
    n_fail++;
    close_out();
  end
  initial
  begin
    nrst = 1'b0;
    irq_status = 16'h0000;
    global_irq_en = 1'b0;
    sdata = 16'($urandom(32'h301EA753));
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    rd(UHMR_RD_ENABLE, UHMR_ENABLE_RST);
    rd(UHMR_RD_SCRATCH, UHMR_SCRATCH_RST);
    host_u.access(1'b0, 1'b1, 8'hA7, 16'hFFFF);
    rd(UHMR_RD_IDENT, 16'h5A01);
    rd(8'h29, 16'h0000);
    host_u.access(1'b0, 1'b1, UHMR_WR_SCRATCH, sdata);
    rd(UHMR_RD_SCRATCH, sdata);
    host_u.access(1'b0, 1'b1, UHMR_WR_ENABLE, 16'hFFFF);
    rd(UHMR_RD_ENABLE, UHMR_ENABLE_MASK);
    check("irq enable", irq_enable, UHMR_ENABLE_MASK);
    irq_status = 16'hFF88;
    global_irq_en = 1'b1;
    irq_chk(1'b0);
    foreach (bits[i])
    begin
      host_u.access(1'b0, 1'b1, UHMR_WR_ENABLE, 16'h0001 << bits[i]);
      irq_status = 16'($urandom) & ~(16'h0001 << bits[i]);
      irq_chk(1'b0);
      irq_status = 16'($urandom) | (16'h0001 << bits[i]);
      irq_chk(1'b1);
      global_irq_en = 1'b0;
      irq_chk(1'b0);
      global_irq_en = 1'b1;
    end
    host_u.access(1'b0, 1'b1, UHMR_WR_SOFTRST, 16'h01F6);
    rd(UHMR_RD_SCRATCH, sdata);
    host_u.access(1'b0, 1'b1, UHMR_WR_SOFTRST, UHMR_SOFTRST_KEY);
    rd(UHMR_RD_SCRATCH, UHMR_SCRATCH_RST);
    rd(UHMR_RD_ENABLE, UHMR_ENABLE_RST);
    irq_chk(1'b0);
    check("irq enable", irq_enable, UHMR_ENABLE_RST);
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    check("reset pulses", pulses[15:0], 16'h0001);
    close_out();
  end
endmodule // usb_host_misc_regs_tb
`default_nettype wire
